// *** rtl/bsr_regs.vh ***
`ifndef BSR_REGS_VH
`define BSR_REGS_VH
// Register offsets (subaddress)
`define BSR_ADDR_BUCK3 8'h18
`define BSR_ADDR_BB 8'h19
// Field positions
`define BSR_PSKIP_BIT 7
`define BSR_RSVD_BIT 6
`define BSR_CODE_MSB 5
// Reset values
`define BSR_BUCK3_RST 8'h98
`define BSR_BB_RST 8'hb2
`define BSR_PSKIP_RST 1'b1
`define BSR_BUCK3_RST_CODE 6'h18
`define BSR_BB_RST_CODE 6'h32
`define BSR_BUCK3_RST_MV 12'd1500
`define BSR_BB_RST_MV 12'd3300
// Power-up values when the default select resistor picks the alternate set
`define BSR_BUCK3_ALT 8'h9d
`define BSR_BB_ALT 8'hb0
// Voltage code map, millivolts
`define BSR_B3_BASE_MV 12'd900
`define BSR_B3_HI_CODE 6'h1a
`define BSR_B3_HI_MV 12'd1550
`define BSR_BB_BASE_MV 12'd1175
`define BSR_BB_HI_CODE 6'h10
`define BSR_BB_HI_MV 12'd1600
`define BSR_BB_LAST_CODE 6'h34
`define BSR_FINE_STEP_MV 12'd25
`define BSR_COARSE_STEP_MV 12'd50
// Monitor blanking time
`define BSR_CLK_MHZ 18'd50
`define BSR_BLANK_TIME_US 18'd5000
`define BSR_BLANK_CYCLES (`BSR_BLANK_TIME_US * `BSR_CLK_MHZ)
`endif

// *** rtl/bsr_blank_timer.v ***
`timescale 1ns/1ns
`include "bsr_regs.vh"
module bsr_blank_timer #(
  parameter [17:0] CYCLES = `BSR_BLANK_CYCLES
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Control
  input wire start,
  // Status
  output reg active_r
);
  reg [17:0] cnt_r;

  // A new write restarts the full interval rather than extending it
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 18'h0;
      active_r <= 1'b0;
    end else if (start) begin
      cnt_r <= CYCLES;
      active_r <= 1'b1;
    end else if (cnt_r != 18'h0) begin
      cnt_r <= cnt_r - 18'h1;
      active_r <= (cnt_r > 18'h1);
    end else begin
      active_r <= 1'b0;
    end
  end
endmodule

// *** rtl/bsr_setpoint_regs.v ***
// Contract
// RULE1: Bit 7 enables pulse skip, resets to one
// RULE2: Enable only permits skipping, not status
// RULE3: Buck3 code maps 0.900V upward, 25/50mV steps
// RULE4: Buck3 codes 1Ah-1Fh continue in 50mV steps
// RULE5: Buck-boost register at 0x19, reset 0xB2
// RULE6: Writes accepted only after password unlock
// RULE7: Write blanks rail monitors for 5 ms
// RULE8: Default select resistor may change power-up value
// RULE9: Host never programs reserved buck-boost codes
// RULE10: Host changes buck-boost code only while off
// RULE11: Buck3 register at 0x18, reset 0x98
// RULE12: Buck-boost code 0h=1.175V to 34h=3.400V
`timescale 1ns/1ns
`include "bsr_regs.vh"
module bsr_setpoint_regs #(
  parameter [17:0] BLANK_CYCLES = `BSR_BLANK_CYCLES
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Register access port
  input wire [7:0] addr,
  input wire wr_en,
  input wire [7:0] wr_data,
  input wire rd_en,
  output reg [7:0] rd_data_r,
  output reg rd_valid_r,
  output reg wr_refused_r,
  // Password unlock state from the protection logic
  input wire wr_unlocked,
  // Default select strap, sampled once after reset release
  input wire default_select_resistor,
  // Converter controls
  output reg buck3_pulse_skip_en_r,
  output reg [5:0] buck3_voltage_code_r,
  output reg [11:0] buck3_mv_r,
  output reg bb_pulse_skip_en_r,
  output reg [5:0] buck_boost_voltage_code_r,
  output reg [11:0] bb_mv_r,
  output reg bb_code_reserved_r,
  // Monitor blanking
  output wire buck3_monitor_blank_r,
  output wire bb_monitor_blank_r
);
  reg [7:0] buck3_setpoint_r;
  reg [7:0] buck3_setpoint_nxt;
  reg [7:0] buck_boost_setpoint_r;
  reg [7:0] buck_boost_setpoint_nxt;
  reg strap_done_r;
  reg [7:0] rd_data_nxt;
  wire [1:0] sel;
  wire wr_ok;
  wire wr_b3;
  wire wr_bb;
  wire wr_drop;
  wire [1:0] blank_start;
  wire [1:0] blank_act;

  function [11:0] buck3_mv;
    input [5:0] code;
    begin
      if (code < `BSR_B3_HI_CODE)
        buck3_mv = `BSR_B3_BASE_MV + `BSR_FINE_STEP_MV * {6'h0, code}; // RULE3
      else
        buck3_mv = `BSR_B3_HI_MV +
          `BSR_COARSE_STEP_MV * {6'h0, code - `BSR_B3_HI_CODE}; // RULE4
    end
  endfunction

  function [11:0] bb_mv;
    input [5:0] code;
    begin
      if (code < `BSR_BB_HI_CODE)
        bb_mv = `BSR_BB_BASE_MV + `BSR_FINE_STEP_MV * {6'h0, code}; // RULE12
      else
        bb_mv = `BSR_BB_HI_MV +
          `BSR_COARSE_STEP_MV * {6'h0, code - `BSR_BB_HI_CODE}; // RULE12
    end
  endfunction

  // Subaddress decode as a one-hot select, shared by write, refusal and read
  function [1:0] reg_sel;
    input [7:0] a;
    begin
      case (a)
        `BSR_ADDR_BUCK3: reg_sel = 2'b01; // RULE11
        `BSR_ADDR_BB: reg_sel = 2'b10; // RULE5
        default: reg_sel = 2'b00;
      endcase
    end
  endfunction

  // Reserved bit 6 is never stored, so it always reads back as zero
  function [7:0] store_val;
    input [7:0] d;
    begin
      store_val = d;
      store_val[`BSR_RSVD_BIT] = 1'b0;
    end
  endfunction

  assign sel = reg_sel(addr);
  // Locked writes are dropped whole, so a stray bus write cannot move a rail
  assign wr_ok = wr_en && wr_unlocked && strap_done_r; // RULE6
  assign wr_b3 = wr_ok && sel[0]; // RULE11
  assign wr_bb = wr_ok && sel[1]; // RULE5
  assign wr_drop = wr_en && (sel != 2'b00) && !(wr_unlocked && strap_done_r); // RULE6
  // A refused write must not blank the monitors either
  assign blank_start = {wr_bb, wr_b3};

  // Next register values; the strap edge wins over any write in that cycle
  always @* begin
    buck3_setpoint_nxt = buck3_setpoint_r;
    buck_boost_setpoint_nxt = buck_boost_setpoint_r;
    if (!strap_done_r) begin
      if (default_select_resistor) begin
        buck3_setpoint_nxt = `BSR_BUCK3_ALT; // RULE8
        buck_boost_setpoint_nxt = `BSR_BB_ALT; // RULE8
      end
    end else begin
      if (wr_b3) begin
        buck3_setpoint_nxt = store_val(wr_data);
      end
      if (wr_bb) begin
        buck_boost_setpoint_nxt = store_val(wr_data);
      end
    end
  end

  // Register storage; strap caught on the first edge after release
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      buck3_setpoint_r <= `BSR_BUCK3_RST; // RULE11 RULE1
      buck_boost_setpoint_r <= `BSR_BB_RST; // RULE5 RULE1
      strap_done_r <= 1'b0;
    end else begin
      buck3_setpoint_r <= buck3_setpoint_nxt;
      buck_boost_setpoint_r <= buck_boost_setpoint_nxt;
      strap_done_r <= 1'b1;
    end
  end

  // Read select; unmapped subaddresses read as zero
  always @* begin
    case (sel)
      2'b01: rd_data_nxt = buck3_setpoint_r;
      2'b10: rd_data_nxt = buck_boost_setpoint_r;
      default: rd_data_nxt = 8'h00;
    endcase
  end

  // Read data holds until the next read so a slow host can still pick it up
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_r <= 8'h00;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= rd_en;
      if (rd_en) begin
        rd_data_r <= rd_data_nxt;
      end
    end
  end

  // A refused write leaves a one-cycle trace so the host can tell it was lost
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_refused_r <= 1'b0;
    end else begin
      wr_refused_r <= wr_drop; // RULE6
    end
  end

  // Buck3 controls; the enable bit is a permission, not a mode report
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      buck3_pulse_skip_en_r <= `BSR_PSKIP_RST;
      buck3_voltage_code_r <= `BSR_BUCK3_RST_CODE;
      buck3_mv_r <= `BSR_BUCK3_RST_MV;
    end else begin
      buck3_pulse_skip_en_r <= buck3_setpoint_r[`BSR_PSKIP_BIT]; // RULE1 RULE2
      buck3_voltage_code_r <= buck3_setpoint_r[`BSR_CODE_MSB:0];
      buck3_mv_r <= buck3_mv(buck3_setpoint_r[`BSR_CODE_MSB:0]); // RULE3
    end
  end

  // Buck-boost controls; reserved codes are kept as written and only flagged
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bb_pulse_skip_en_r <= `BSR_PSKIP_RST;
      buck_boost_voltage_code_r <= `BSR_BB_RST_CODE;
      bb_mv_r <= `BSR_BB_RST_MV;
      bb_code_reserved_r <= 1'b0;
    end else begin
      bb_pulse_skip_en_r <= buck_boost_setpoint_r[`BSR_PSKIP_BIT]; // RULE1 RULE2
      buck_boost_voltage_code_r <= buck_boost_setpoint_r[`BSR_CODE_MSB:0];
      bb_mv_r <= bb_mv(buck_boost_setpoint_r[`BSR_CODE_MSB:0]); // RULE12
      bb_code_reserved_r <=
        buck_boost_setpoint_r[`BSR_CODE_MSB:0] > `BSR_BB_LAST_CODE; // RULE9
    end
  end

  // One blanking timer per rail, restarted by each accepted write
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_blank
      bsr_blank_timer #(
        .CYCLES(BLANK_CYCLES)
      ) u_timer (
        .clk(clk),
        .rst_b(rst_b),
        .start(blank_start[gi]), // RULE7
        .active_r(blank_act[gi])
      );
    end
  endgenerate

  assign buck3_monitor_blank_r = blank_act[0];
  assign bb_monitor_blank_r = blank_act[1];
endmodule

// *** verification/bsr_props.sv ***
`timescale 1ns/1ns
module bsr_props #(parameter int N = 20) (
  // Watched ports
  input wire logic clk, rst_b, wr_en, rd_en, wr_unlocked, rd_valid_r, wr_refused_r,
  input wire logic bb_pulse_skip_en_r, bb_code_reserved_r, bb_monitor_blank_r,
  input wire logic [7:0] addr, wr_data, rd_data_r,
  input wire logic [5:0] buck3_voltage_code_r, buck_boost_voltage_code_r
);
  logic [17:0] bc;
  wire wb = wr_en && wr_unlocked && addr == 8'h19;
  wire w3 = wr_en && wr_unlocked && addr == 8'h18;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Retrigger lengthens blanking, so only a floor is checked
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) bc <= '0;
    else bc <= bb_monitor_blank_r ? bc + 18'd1 : '0;
  chk_bb_store: assert property (wb ##1 !wr_refused_r |=>
    {bb_pulse_skip_en_r, 1'b0, buck_boost_voltage_code_r} == ($past(wr_data, 2) & 8'hbf))
    else $error("bb store");
  chk_b3_store: assert property (w3 ##1 !wr_refused_r |=>
    {2'b00, buck3_voltage_code_r} == ($past(wr_data, 2) & 8'h3f)) else $error("b3 store");
  chk_lock_refuse: assert property (
    wr_en && !wr_unlocked && addr[7:1] == 7'h0c |=> wr_refused_r) else $error("lock");
  chk_lock_hold: assert property (
    !wr_unlocked ##1 wr_refused_r |=> $stable(buck_boost_voltage_code_r)) else $error("hold");
  chk_blank_rise: assert property (
    wb ##1 !wr_refused_r |-> bb_monitor_blank_r) else $error("blank rise");
  chk_blank_len: assert property (
    $fell(bb_monitor_blank_r) |-> bc >= N) else $error("blank short");
  chk_rsv_flag: assert property (
    bb_code_reserved_r == (buck_boost_voltage_code_r > 6'h34)) else $error("reserved");
  chk_rd_answer: assert property (
    rd_en |=> rd_valid_r && !rd_data_r[6]) else $error("read");
  cover property (wb ##1 bb_monitor_blank_r);
  cover property (wr_refused_r);
  cover property ($fell(bb_monitor_blank_r));
endmodule

// *** verification/bsr_host.sv ***
`timescale 1ns/1ns
module bsr_host (
  // Clock
  input wire logic clk,
  // Register port drive
  output logic [7:0] addr, wr_data,
  output logic wr_en, rd_en, wr_unlocked
);
  // Buck-boost converter is kept off here, so its setpoint may be written
  logic bb_running = 1'b0;
  initial {addr, wr_data, wr_en, rd_en, wr_unlocked} = '0;
  // Idle edge after each access keeps strobes one cycle long
  task automatic xfer(input logic w, input logic [7:0] a, d);
    @(posedge clk);
    addr <= a;
    wr_data <= (w && a == 8'h19 && d[5:0] > 6'h34) ? {d[7:6], 6'h34} : d;
    wr_en <= w && !(a == 8'h19 && bb_running);
    rd_en <= !w;
    @(posedge clk);
    addr <= ~a;
    wr_data <= ~d;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask
  task automatic unlock();
    @(posedge clk);
    wr_unlocked <= 1'b1;
  endtask
endmodule

// *** verification/bsr_setpoint_regs_tb.sv ***
`timescale 1ns/1ns
module bsr_setpoint_regs_tb;
  logic clk = 0, rst_b = 0, default_select_resistor = 0, wr_en, rd_en, wr_unlocked;
  logic rd_valid_r, wr_refused_r, buck3_pulse_skip_en_r, bb_pulse_skip_en_r;
  logic bb_code_reserved_r, buck3_monitor_blank_r, bb_monitor_blank_r;
  logic [7:0] addr, wr_data, rd_data_r, a;
  logic [5:0] buck3_voltage_code_r, buck_boost_voltage_code_r, c;
  logic [5:0] cn [8] = '{6'h19, 6'h1a, 6'h1f, 6'h20, 6'h3f, 6'h0f, 6'h10, 6'h34};
  logic [11:0] buck3_mv_r, bb_mv_r;
  logic [31:0] r, rs = 32'ha29a;
  int err_count = 0, checked = 0;
  always #10 clk = ~clk;
  bsr_host h (
    .clk(clk), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .wr_unlocked(wr_unlocked));
  bsr_setpoint_regs #(.BLANK_CYCLES(18'd20)) DUT (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wr_en(wr_en), .wr_data(wr_data),
    .rd_en(rd_en), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
    .wr_refused_r(wr_refused_r), .wr_unlocked(wr_unlocked),
    .default_select_resistor(default_select_resistor),
    .buck3_pulse_skip_en_r(buck3_pulse_skip_en_r), .buck3_voltage_code_r(buck3_voltage_code_r),
    .buck3_mv_r(buck3_mv_r), .bb_pulse_skip_en_r(bb_pulse_skip_en_r),
    .buck_boost_voltage_code_r(buck_boost_voltage_code_r), .bb_mv_r(bb_mv_r),
    .bb_code_reserved_r(bb_code_reserved_r), .buck3_monitor_blank_r(buck3_monitor_blank_r),
    .bb_monitor_blank_r(bb_monitor_blank_r));
  function logic [31:0] nx();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  function logic [11:0] mv(input logic bb, input logic [5:0] k);
    if (bb) return k < 6'h10 ? 12'd1175 + 12'd25 * k : 12'd1600 + 12'd50 * (k - 6'h10);
    return k < 6'h1a ? 12'd900 + 12'd25 * k : 12'd1550 + 12'd50 * (k - 6'h1a);
  endfunction
  task chk(input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task report_and_stop();
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task rd(input logic [7:0] ad, exp);
    h.xfer(0, ad, 8'h00);
    #1 chk({rd_valid_r, rd_data_r}, {1'b1, exp});
  endtask
  task wr(input logic [7:0] ad, d);
    h.xfer(1, ad, d);
    #1 chk({ad[0] ? bb_monitor_blank_r : buck3_monitor_blank_r, wr_refused_r},
      2'b10);
    @(posedge clk);
    #1 chk(ad[0] ? {bb_pulse_skip_en_r, buck_boost_voltage_code_r, bb_mv_r}
      : {buck3_pulse_skip_en_r, buck3_voltage_code_r, buck3_mv_r},
      {d[7], d[5:0], mv(ad[0], d[5:0])});
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1;
    repeat (3) @(posedge clk);
    rd(8'h18, 8'h98);
    rd(8'h19, 8'hb2);
    h.xfer(1, 8'h19, 8'h05);
    #1 chk({wr_refused_r, bb_monitor_blank_r}, 2'b10);
    rd(8'h19, 8'hb2);
    $display("reset and lock test done");
    h.unlock();
    for (int i = 0; i < 40; i++) begin
      r = nx();
      a = {7'h0c, i < 8 ? i > 4 : r[8]};
      c = i < 8 ? cn[i] : r[5:0];
      if (a[0]) c = c % 6'h35;
      wr(a, {r[7:6], c});
      rd(a, {r[7], 1'b0, c});
    end
    repeat (25) @(posedge clk);
    #1 chk({buck3_monitor_blank_r, bb_monitor_blank_r}, 0);
    rd(8'h00, 8'h00);
    $display("setpoint test done");
    @(posedge clk);
    rst_b <= 0;
    default_select_resistor <= 1;
    repeat (6) @(posedge clk);
    rst_b <= 1;
    repeat (3) @(posedge clk);
    rd(8'h18, 8'h9d);
    rd(8'h19, 8'hb0);
    chk({buck3_pulse_skip_en_r, buck3_voltage_code_r, buck3_mv_r},
      {1'b1, 6'h1d, mv(0, 6'h1d)});
    chk({bb_pulse_skip_en_r, buck_boost_voltage_code_r, bb_mv_r},
      {1'b1, 6'h30, mv(1, 6'h30)});
    $display("strap test done");
    report_and_stop();
  end
  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end
endmodule
bind bsr_setpoint_regs bsr_props #(.N(BLANK_CYCLES)) u_props (
  .clk(clk), .rst_b(rst_b), .wr_en(wr_en), .rd_en(rd_en), .wr_unlocked(wr_unlocked),
  .rd_valid_r(rd_valid_r), .wr_refused_r(wr_refused_r),
  .bb_pulse_skip_en_r(bb_pulse_skip_en_r), .bb_code_reserved_r(bb_code_reserved_r),
  .bb_monitor_blank_r(bb_monitor_blank_r), .addr(addr), .wr_data(wr_data),
  .rd_data_r(rd_data_r), .buck3_voltage_code_r(buck3_voltage_code_r),
  .buck_boost_voltage_code_r(buck_boost_voltage_code_r));
